/* rtl/srtc_core.sv */
`timescale 1ns/1ps
// Behaviour
// - Pointer advances by one after every data byte, read or write.
// - Time held in BCD, hundredths through century, 24-hour hours.
// - Date rolls over by month length, leap February included.
// - Square wave runs at its top rate from reset until reprogrammed.
// - Square wave rate selectable from 1 Hz to the top rate.
// - The fixed top-rate output can be switched off by software.
// - Watchdog timeout programmable from 62.5 ms to 31 minutes.
// - Eight time bytes plus eight control and status bytes.
// - A stopped oscillator is detected and flagged for software.
// - Time base divided down from the 32.768 kHz oscillator.
// - Calibration value trims the rate by up to about 2 ppm.
// - Registers reached over a two-wire bus as addressed target.
// - Any time write clears hundredths; hundredths only accept 00.
// - User copy frozen while pointer is 00h-07h; resumes on STOP.
module srtc_core
	import srtc_pkg::*;
#(
	parameter int unsigned OSC_STOP_CYCLES = OSC_STOP_CYCLES_DEF
)(
	input  wire logic clock,                 // System clock
	input  wire logic rst,                   // Synchronous reset
	input  wire logic crystalIn,             // Oscillator clock
	input  wire logic scl,                   // Bus clock pin
	input  wire logic sdaIn,                 // Bus data pin level
	output logic      sdaOut,                // Bus data drive value
	output logic      sdaDriveN,             // Low while pulling SDA
	output logic      squareWaveOut,         // Programmable square wave
	output logic      fixed32kOut,           // Fixed top-rate output
	output logic      watchdogTimeoutOut,    // Watchdog drive value
	output logic      watchdogTimeoutDriveN  // Low while watchdog fired
);

	logic        oscRstSync1;
	logic        oscRstSync2;
	logic [14:0] oscCount;
	logic [14:0] hundAcc;
	logic [15:0] hundSum;
	logic        hundToggle;
	logic [5:0]  cfgSys;
	logic [5:0]  cfgSync1;
	logic [5:0]  cfgSync2;
	logic [5:0]  cfgSync3;
	logic [5:0]  cfgOsc;

	srtc_bus_t   busSync1;
	srtc_bus_t   busSync2;
	srtc_bus_t   busPrev;
	srtc_lvl_t   lvlRaw;
	srtc_lvl_t   lvlSync1;
	srtc_lvl_t   lvlSync2;
	srtc_lvl_t   lvlPrev;
	logic        sclRise;
	logic        sclFall;
	logic        startCond;
	logic        stopCond;
	logic        hundTick;
	logic        tick16;
	logic        tick4;
	logic        tick1;

	srtc_state_t state;
	logic [3:0]  bitCnt;
	logic [7:0]  shift;
	logic [3:0]  ptr;
	logic        readMode;
	logic        masterAck;
	logic        busActive;
	srtc_wr_t    wr;
	logic [7:0]  readByte;

	logic [7:0]  timeReg [0:7];
	logic [7:0]  userReg [0:7];
	logic [7:0]  ctrlReg [0:7];
	logic [7:0]  nextTime [0:7];
	logic        advance;
	logic        extraPend;
	logic        inCorr;
	logic [CAL_WINDOW_BITS-1:0] calWindow;

	logic [4:0]  wdCount;
	logic [5:0]  wdPrescale;
	logic        wdTick;
	logic        wdExpire;
	logic [19:0] stopCount;
	logic        oscStopEvt;

	function automatic logic [7:0] bcdStep(input logic [7:0] v,
		input logic [7:0] maxV, input logic [7:0] minV);
		if (v == maxV)
			return minV;
		else if (v[3:0] == 4'h9)
			return {v[7:4] + 4'h1, 4'h0};
		else
			return {v[7:4], v[3:0] + 4'h1};
	endfunction : bcdStep

	function automatic logic [7:0] monthLast(input logic [7:0] mon,
		input logic [7:0] yr);
		logic leap;
		leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
			: (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
		if (mon == 8'h02)
			return leap ? 8'h29 : 8'h28;
		else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09
			|| mon == 8'h11)
			return 8'h30;
		else
			return 8'h31;
	endfunction : monthLast

	// Oscillator domain: free divider, hundredths phase, output waves
	always_ff @(posedge crystalIn)
	begin
		oscRstSync1 <= rst;
		oscRstSync2 <= oscRstSync1;
	end

	// Config word taken only once two samples agree, so no torn value
	always_ff @(posedge crystalIn)
	begin
		cfgSync1 <= cfgSys;
		cfgSync2 <= cfgSync1;
		cfgSync3 <= cfgSync2;
		if (oscRstSync2)
			cfgOsc <= CFG_RESET;
		else if (cfgSync2 == cfgSync3)
			cfgOsc <= cfgSync3;
	end

	assign hundSum = {1'b0, hundAcc} + HUND_STEP;

	always_ff @(posedge crystalIn)
	begin
		if (oscRstSync2)
		begin
			oscCount   <= '0;
			hundAcc    <= '0;
			hundToggle <= 1'b0;
		end
		else
		begin
			oscCount <= oscCount + 15'h1;
			hundAcc  <= hundSum[14:0];
			if (hundSum[15])
				hundToggle <= ~hundToggle;
		end
	end

	// Top rate is the oscillator halved; a flop cannot pass it whole
	// Waves leave from crystal flops: the system clock would alias them
	always_ff @(posedge crystalIn)
	begin
		if (oscRstSync2)
		begin
			squareWaveOut <= 1'b0;
			fixed32kOut   <= 1'b0;
		end
		else
		begin
			squareWaveOut <= cfgOsc[4] && (cfgOsc[3:0] != 4'h0)
				&& oscCount[cfgOsc[3:0] - 4'h1];
			fixed32kOut   <= cfgOsc[5] && oscCount[0];
		end
	end

	assign cfgSys = {ctrlReg[C_OUTCFG][FIXED_32K_OUT_EN_BIT],
		ctrlReg[C_OUTCFG][SQWE_BIT], timeReg[T_DAY][RS_LSB +: 4]};

	assign lvlRaw = '{act: oscCount[TAP_ACT], t16: oscCount[TAP_16HZ],
		t4: oscCount[TAP_4HZ], t1: oscCount[TAP_1HZ], hund: hundToggle,
		square: squareWaveOut, fixed: fixed32kOut};

	// System domain synchronisers
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			busSync1 <= 2'b11;
			busSync2 <= 2'b11;
			busPrev  <= 2'b11;
			lvlSync1 <= '0;
			lvlSync2 <= '0;
			lvlPrev  <= '0;
		end
		else
		begin
			busSync1 <= '{scl: scl, sda: sdaIn};
			busSync2 <= busSync1;
			busPrev  <= busSync2;
			lvlSync1 <= lvlRaw;
			lvlSync2 <= lvlSync1;
			lvlPrev  <= lvlSync2;
		end
	end

	assign sclRise   = busSync2.scl & ~busPrev.scl;
	assign sclFall   = ~busSync2.scl & busPrev.scl;
	assign startCond = busPrev.scl & busSync2.scl
		& busPrev.sda & ~busSync2.sda;
	assign stopCond  = busPrev.scl & busSync2.scl
		& ~busPrev.sda & busSync2.sda;
	assign hundTick  = lvlSync2.hund ^ lvlPrev.hund;
	assign tick16    = lvlSync2.t16 & ~lvlPrev.t16;
	assign tick4     = lvlSync2.t4 & ~lvlPrev.t4;
	assign tick1     = lvlSync2.t1 & ~lvlPrev.t1;

	assign readByte = ptr[3] ? ctrlReg[ptr[2:0]] : userReg[ptr[2:0]];

	// Bus target engine
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			state     <= S_IDLE;
			bitCnt    <= '0;
			shift     <= '0;
			ptr       <= '0;
			readMode  <= 1'b0;
			masterAck <= 1'b0;
			busActive <= 1'b0;
			sdaDriveN <= 1'b1;
			wr        <= '0;
		end
		else
		begin
			wr.en <= 1'b0;
			if (startCond)
			begin
				state     <= S_ADDR;
				bitCnt    <= '0;
				sdaDriveN <= 1'b1;
			end
			else if (stopCond)
			begin
				state     <= S_IDLE;
				sdaDriveN <= 1'b1;
				busActive <= 1'b0;
			end
			else
			begin
				if ((state == S_ADDR || state == S_WORD || state == S_WRITE)
					&& sclRise)
				begin
					shift  <= {shift[6:0], busSync2.sda};
					bitCnt <= bitCnt + 4'h1;
				end
				unique case (state)
					S_IDLE:
						;
					S_ADDR:
						if (sclFall && bitCnt == 4'h8)
						begin
							if (shift[7:1] == SLAVE_ADDR)
							begin
								sdaDriveN <= 1'b0;
								readMode  <= shift[0];
								busActive <= 1'b1;
								state     <= S_ADDR_ACK;
							end
							else
								state <= S_IDLE;
						end
					S_WORD:
						if (sclFall && bitCnt == 4'h8)
						begin
							ptr       <= shift[3:0];
							sdaDriveN <= 1'b0;
							state     <= S_WORD_ACK;
						end
					S_WRITE:
						if (sclFall && bitCnt == 4'h8)
						begin
							wr        <= '{en: 1'b1, addr: ptr, data: shift};
							ptr       <= ptr + 4'h1;
							sdaDriveN <= 1'b0;
							state     <= S_WRITE_ACK;
						end
					S_ADDR_ACK:
						if (sclFall)
						begin
							bitCnt <= readMode ? 4'h1 : 4'h0;
							if (readMode)
							begin
								shift     <= readByte;
								sdaDriveN <= readByte[7];
								state     <= S_READ;
							end
							else
							begin
								sdaDriveN <= 1'b1;
								state     <= S_WORD;
							end
						end
					S_WORD_ACK, S_WRITE_ACK:
						if (sclFall)
						begin
							bitCnt    <= '0;
							sdaDriveN <= 1'b1;
							state     <= S_WRITE;
						end
					S_READ:
						if (sclFall)
						begin
							if (bitCnt == 4'h8)
							begin
								sdaDriveN <= 1'b1;
								state     <= S_READ_ACK;
							end
							else
							begin
								sdaDriveN <= shift[6];
								shift     <= {shift[6:0], 1'b0};
								bitCnt    <= bitCnt + 4'h1;
							end
						end
					S_READ_ACK:
						if (sclRise)
						begin
							masterAck <= ~busSync2.sda;
							ptr       <= ptr + 4'h1;
						end
						else if (sclFall)
						begin
							bitCnt <= 4'h1;
							if (masterAck)
							begin
								shift     <= readByte;
								sdaDriveN <= readByte[7];
								state     <= S_READ;
							end
							else
								state <= S_IDLE;
						end
					default:
						state <= S_IDLE;
				endcase
			end
		end
	end

	// Calibration: first N hundredths of each window doubled or dropped
	assign inCorr  = calWindow <
		{{(CAL_WINDOW_BITS-5){1'b0}}, ctrlReg[C_CAL][4:0]};
	assign advance = !timeReg[T_SEC][STOP_BIT] && (extraPend
		|| (hundTick && !(inCorr && !ctrlReg[C_CAL][CAL_SIGN_BIT])));

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			calWindow <= '0;
			extraPend <= 1'b0;
		end
		else
		begin
			if (hundTick)
				calWindow <= calWindow
					+ {{(CAL_WINDOW_BITS-1){1'b0}}, 1'b1};
			extraPend <= hundTick && inCorr
				&& ctrlReg[C_CAL][CAL_SIGN_BIT];
		end
	end

	// Carry chain across the BCD time bytes
	always_comb
	begin
		logic [7:0] c;
		logic [7:0] last;
		c    = '0;
		last = monthLast({3'h0, timeReg[T_MONTH][4:0]}, timeReg[T_YEAR]);
		for (int i = 0; i < 8; i++)
			nextTime[i] = timeReg[i];
		c[0] = advance;
		c[1] = c[0] && timeReg[T_HUND] == HUND_MAX;
		c[2] = c[1] && timeReg[T_SEC][6:0] == SEC_MAX[6:0];
		c[3] = c[2] && timeReg[T_MIN][6:0] == SEC_MAX[6:0];
		c[4] = c[3] && timeReg[T_HOUR][5:0] == HOUR_MAX[5:0];
		c[5] = c[4] && timeReg[T_DATE] == last;
		c[6] = c[5] && timeReg[T_MONTH][4:0] == MONTH_MAX[4:0];
		c[7] = c[6] && timeReg[T_YEAR] == YEAR_MAX;
		if (c[0])
			nextTime[T_HUND] = bcdStep(timeReg[T_HUND], HUND_MAX, BCD_ZERO);
		if (c[1])
			nextTime[T_SEC][6:0] = 7'(bcdStep(
				{1'b0, timeReg[T_SEC][6:0]}, SEC_MAX, BCD_ZERO));
		if (c[2])
			nextTime[T_MIN][6:0] = 7'(bcdStep(
				{1'b0, timeReg[T_MIN][6:0]}, SEC_MAX, BCD_ZERO));
		if (c[3])
			nextTime[T_HOUR][5:0] = 6'(bcdStep(
				{2'h0, timeReg[T_HOUR][5:0]}, HOUR_MAX, BCD_ZERO));
		if (c[4])
		begin
			nextTime[T_DAY][2:0] = 3'(bcdStep(
				{5'h0, timeReg[T_DAY][2:0]}, DAY_MAX, BCD_ONE));
			nextTime[T_DATE] = bcdStep(timeReg[T_DATE], last, BCD_ONE);
		end
		if (c[5])
			nextTime[T_MONTH][4:0] = 5'(bcdStep(
				{3'h0, timeReg[T_MONTH][4:0]}, MONTH_MAX, BCD_ONE));
		if (c[6])
			nextTime[T_YEAR] = bcdStep(timeReg[T_YEAR], YEAR_MAX, BCD_ZERO);
		if (c[7])
			nextTime[T_MONTH][7:CENT_LSB] = timeReg[T_MONTH][7:CENT_LSB]
				+ 2'h1;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			for (int i = 0; i < 8; i++)
				timeReg[i] <= TIME_RESET[i*8 +: 8];
		else if (wr.en && !wr.addr[3])
		begin
			timeReg[wr.addr[2:0]] <= wr.data;
			timeReg[T_HUND]       <= BCD_ZERO;
		end
		else
			for (int i = 0; i < 8; i++)
				timeReg[i] <= nextTime[i];
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			for (int i = 0; i < 8; i++)
				userReg[i] <= TIME_RESET[i*8 +: 8];
		else if (!(busActive && !ptr[3]))
			for (int i = 0; i < 8; i++)
				userReg[i] <= timeReg[i];
	end

	// Hardware sets after the software write, so a set wins
	always_ff @(posedge clock)
	begin
		if (rst)
			for (int i = 0; i < 8; i++)
				ctrlReg[i] <= CTRL_RESET[i*8 +: 8];
		else
		begin
			if (wr.en && wr.addr[3])
				ctrlReg[wr.addr[2:0]] <= wr.data;
			if (oscStopEvt)
				ctrlReg[C_FLAGS][OF_BIT] <= 1'b1;
			if (wdExpire)
				ctrlReg[C_FLAGS][WDF_BIT] <= 1'b1;
		end
	end

	// Oscillator stop: no divider activity for the whole timeout
	always_ff @(posedge clock)
	begin
		if (rst || lvlSync2.act != lvlPrev.act)
			stopCount <= '0;
		else if (stopCount != 20'(OSC_STOP_CYCLES))
			stopCount <= stopCount + 20'h1;
	end

	assign oscStopEvt = stopCount == 20'(OSC_STOP_CYCLES) - 20'h1;

	// Watchdog: multiplier times resolution, reloaded on each write
	always_comb
	begin
		unique case (srtc_wdres_t'(ctrlReg[C_WDOG][1:0]))
			WD_RES_16HZ: wdTick = tick16;
			WD_RES_4HZ:  wdTick = tick4;
			WD_RES_1HZ:  wdTick = tick1;
			WD_RES_MIN:  wdTick = tick1 && wdPrescale == SEC_LAST;
		endcase
	end

	assign wdExpire = wdTick && wdCount == 5'h1;

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			wdCount    <= '0;
			wdPrescale <= '0;
		end
		else if (wr.en && wr.addr == {1'b1, C_WDOG})
		begin
			wdCount    <= wr.data[WD_MULT_LSB +: 5];
			wdPrescale <= '0;
		end
		else
		begin
			if (tick1)
				wdPrescale <= (wdPrescale == SEC_LAST) ? 6'h0
					: wdPrescale + 6'h1;
			if (wdTick && wdCount != 5'h0)
				wdCount <= wdCount - 5'h1;
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			sdaOut                <= 1'b0;
			watchdogTimeoutOut    <= 1'b0;
			watchdogTimeoutDriveN <= 1'b1;
		end
		else
		begin
			sdaOut        <= 1'b0;
			watchdogTimeoutOut <= 1'b0;
			if (wr.en && wr.addr == {1'b1, C_WDOG})
				watchdogTimeoutDriveN <= 1'b1;
			else if (wdExpire)
				watchdogTimeoutDriveN <= 1'b0;
		end
	end

endmodule : srtc_core

/* rtl/srtc_pkg.sv */
package srtc_pkg;

	localparam logic [6:0] SLAVE_ADDR = 7'h68;

	// Time bytes, 00h-07h
	localparam logic [2:0] T_HUND  = 3'h0;
	localparam logic [2:0] T_SEC   = 3'h1;
	localparam logic [2:0] T_MIN   = 3'h2;
	localparam logic [2:0] T_HOUR  = 3'h3;
	localparam logic [2:0] T_DAY   = 3'h4;
	localparam logic [2:0] T_DATE  = 3'h5;
	localparam logic [2:0] T_MONTH = 3'h6;
	localparam logic [2:0] T_YEAR  = 3'h7;

	// Control bytes, 08h-0Fh, indexed by the low three pointer bits
	localparam logic [2:0] C_CAL    = 3'h0;
	localparam logic [2:0] C_WDOG   = 3'h1;
	localparam logic [2:0] C_OUTCFG = 3'h2;
	localparam logic [2:0] C_FLAGS  = 3'h7;

	localparam int STOP_BIT     = 7;
	localparam int CENT_LSB     = 6;
	localparam int RS_LSB       = 4;
	localparam int SQWE_BIT     = 6;
	localparam int FIXED_32K_OUT_EN_BIT  = 7;
	localparam int CAL_SIGN_BIT = 5;
	localparam int WD_MULT_LSB  = 2;
	localparam int WDF_BIT      = 7;
	localparam int OF_BIT       = 2;

	localparam logic [7:0] HUND_MAX  = 8'h99;
	localparam logic [7:0] SEC_MAX   = 8'h59;
	localparam logic [7:0] HOUR_MAX  = 8'h23;
	localparam logic [7:0] DAY_MAX   = 8'h07;
	localparam logic [7:0] MONTH_MAX = 8'h12;
	localparam logic [7:0] YEAR_MAX  = 8'h99;
	localparam logic [7:0] BCD_ZERO  = 8'h00;
	localparam logic [7:0] BCD_ONE   = 8'h01;

	// Oscillator is 32768 Hz = 2^15 counts per second
	localparam int          OSC_HZ    = 32768;
	localparam logic [15:0] HUND_STEP = 16'h0064;
	localparam int          TAP_ACT   = 4;
	localparam int          TAP_16HZ  = 10;
	localparam int          TAP_4HZ   = 12;
	localparam int          TAP_1HZ   = 14;
	localparam logic [5:0]  SEC_LAST  = 6'h3b;
	localparam int          CAL_WINDOW_BITS = 24;

	localparam int unsigned SYS_HZ      = 10_000_000;
	localparam int unsigned OSC_STOP_US = 5000;
	localparam int unsigned OSC_STOP_CYCLES_DEF =
		OSC_STOP_US * (SYS_HZ / 1_000_000);

	localparam logic [63:0] TIME_RESET = 64'h0001011100000000;
	localparam logic [63:0] CTRL_RESET = 64'h04000000_00c00000;
	localparam logic [5:0]  CFG_RESET  = 6'h31;

	typedef enum logic [1:0] {
		WD_RES_16HZ = 2'b00,
		WD_RES_4HZ  = 2'b01,
		WD_RES_1HZ  = 2'b10,
		WD_RES_MIN  = 2'b11
	} srtc_wdres_t;

	typedef enum logic [3:0] {
		S_IDLE      = 4'b0000,
		S_ADDR      = 4'b0001,
		S_ADDR_ACK  = 4'b0010,
		S_WORD      = 4'b0011,
		S_WORD_ACK  = 4'b0100,
		S_WRITE     = 4'b0101,
		S_WRITE_ACK = 4'b0110,
		S_READ      = 4'b0111,
		S_READ_ACK  = 4'b1000
	} srtc_state_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} srtc_bus_t;

	typedef struct packed {
		logic       en;
		logic [3:0] addr;
		logic [7:0] data;
	} srtc_wr_t;

	typedef struct packed {
		logic act;
		logic t16;
		logic t4;
		logic t1;
		logic hund;
		logic square;
		logic fixed;
	} srtc_lvl_t;

endpackage : srtc_pkg

/* tb/srtc_core_checker.sv */
`timescale 1ns/1ps
module srtc_core_checker
	import srtc_pkg::*;
#(
	parameter int unsigned OSC_STOP_CYCLES = OSC_STOP_CYCLES_DEF
)(
	input wire logic clock,                 // System clock
	input wire logic rst,                   // Sync reset
	input wire logic crystalIn,             // Oscillator
	input wire logic scl,                   // Bus clock
	input wire logic sdaIn,                 // Data wire level
	input wire logic sdaOut,                // Data drive value
	input wire logic sdaDriveN,             // Data pull, low active
	input wire logic squareWaveOut,         // Square wave
	input wire logic fixed32kOut,           // Fixed wave
	input wire logic watchdogTimeoutOut,    // Watchdog value
	input wire logic watchdogTimeoutDriveN  // Watchdog pull
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	chk_sda_opendrain: assert property (sdaOut == 1'b0)
		else $error("data drive value not low");
	chk_wdo_opendrain: assert property (watchdogTimeoutOut == 1'b0)
		else $error("watchdog drive value not low");
	chk_sda_lowphase: assert property ($changed(sdaDriveN) |-> !scl)
		else $error("data pull moved while bus clock high");
	chk_sda_highhold: assert property (
		$rose(scl) |-> $stable(sdaDriveN) [*4])
		else $error("data pull not held over clock high");
	chk_pull_minlen: assert property (
		$fell(sdaDriveN) |-> !sdaDriveN [*6])
		else $error("data pull shorter than one bit");
	chk_stop_release: assert property (
		scl && $rose(sdaIn) |=> sdaDriveN [*4])
		else $error("data pulled right after stop");
	chk_start_listen: assert property (
		scl && $fell(sdaIn) |=> sdaDriveN [*8])
		else $error("data pulled during address byte");
	chk_wdo_release: assert property (
		$rose(watchdogTimeoutDriveN) |-> !sdaDriveN)
		else $error("watchdog released without bus write");

	cover property ($fell(sdaDriveN));
	cover property ($fell(watchdogTimeoutDriveN));
	cover property (scl && $rose(sdaIn));
	cover property (@(posedge crystalIn) $rose(squareWaveOut) && fixed32kOut);
endmodule : srtc_core_checker

bind srtc_core srtc_core_checker #(
	.OSC_STOP_CYCLES(OSC_STOP_CYCLES)
) u_checker (
	.clock(clock), .rst(rst), .crystalIn(crystalIn), .scl(scl),
	.sdaIn(sdaIn), .sdaOut(sdaOut), .sdaDriveN(sdaDriveN),
	.squareWaveOut(squareWaveOut), .fixed32kOut(fixed32kOut),
	.watchdogTimeoutOut(watchdogTimeoutOut),
	.watchdogTimeoutDriveN(watchdogTimeoutDriveN)
);

/* tb/srtc_i2c_master.sv */
`timescale 1ns/1ps
module srtc_i2c_master
	import srtc_pkg::*;
#(
	parameter int HALF = 6
)(
	input  wire logic clock,     // System clock
	input  wire logic sdaWire,   // Resolved data wire
	output logic      scl,       // Bus clock, rests high
	output logic      sdaDriveN  // Low while pulling data
);
	initial
	begin
		scl = 1'b1;
		sdaDriveN = 1'b1;
	end

	task automatic half_bit();
		repeat (HALF) @(negedge clock);
	endtask : half_bit

	// Data moves two cycles after clock falls, never while clock high
	task automatic bit_xfer(input logic b, output logic s);
		sdaDriveN = b;
		half_bit();
		scl = 1'b1;
		half_bit();
		s = sdaWire;
		scl = 1'b0;
		repeat (2) @(negedge clock);
	endtask : bit_xfer

	task automatic start_cond();
		sdaDriveN = 1'b1;
		half_bit();
		scl = 1'b1;
		half_bit();
		sdaDriveN = 1'b0;
		half_bit();
		scl = 1'b0;
		repeat (2) @(negedge clock);
	endtask : start_cond

	task automatic stop_cond();
		sdaDriveN = 1'b0;
		half_bit();
		scl = 1'b1;
		half_bit();
		sdaDriveN = 1'b1;
		half_bit();
	endtask : stop_cond

	task automatic wr_byte(input logic [7:0] d, output logic nack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_xfer(d[i], s);
		bit_xfer(1'b1, nack);
	endtask : wr_byte

	task automatic rd_byte(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
		begin
			bit_xfer(1'b1, s);
			d[i] = s;
		end
		bit_xfer(last, s);
	endtask : rd_byte
endmodule : srtc_i2c_master

/* tb/srtc_core_tb_top.sv */
`timescale 1ns/1ps
module srtc_core_tb_top
	import srtc_pkg::*;
;
	localparam int unsigned STOP_CYC = 200;
	// Year, month, date, then expected date and month after rollover
	localparam logic [39:0] CAL [4] = '{40'h2402282902,
		40'h2302280103, 40'h2402290103, 40'h2304300105};
	logic       clock = 1'b0;
	logic       rst = 1'b1;
	logic       crystalIn = 1'b0;
	logic       xtalRun = 1'b1;
	logic       scl;
	logic       masterN;
	logic       sdaWire;
	logic       sdaOut;
	logic       sdaDriveN;
	logic       squareWaveOut;
	logic       fixed32kOut;
	logic       watchdogTimeoutOut;
	logic       watchdogTimeoutDriveN;
	logic [7:0] wd [0:7];
	logic [7:0] rd [0:15];
	int         sqEdges;
	int         fixEdges;
	int         numErrors = 0;
	int         compares = 0;

	// Pull-up: an undriven device pin counts as released
	assign sdaWire = masterN & (sdaDriveN !== 1'b0);
	always #50 clock = ~clock;
	always @(squareWaveOut) sqEdges++;
	always @(fixed32kOut) fixEdges++;

	initial
	begin
		#7.3;
		forever
			#24 crystalIn = xtalRun ? ~crystalIn : crystalIn;
	end

	srtc_i2c_master host (
		.clock(clock), .sdaWire(sdaWire), .scl(scl), .sdaDriveN(masterN)
	);

	srtc_core #(
		.OSC_STOP_CYCLES(STOP_CYC)
	) DUT (
		.clock(clock), .rst(rst), .crystalIn(crystalIn), .scl(scl),
		.sdaIn(sdaWire), .sdaOut(sdaOut), .sdaDriveN(sdaDriveN),
		.squareWaveOut(squareWaveOut), .fixed32kOut(fixed32kOut),
		.watchdogTimeoutOut(watchdogTimeoutOut),
		.watchdogTimeoutDriveN(watchdogTimeoutDriveN)
	);

	task automatic summarize();
		$display("errors %0d compares %0d", numErrors, compares);
		if (numErrors == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize

	task automatic check_byte(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		compares++;
		if (got !== exp)
		begin
			numErrors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check_byte

	task automatic check_count(input string what, input int lo,
		input int hi, input int got);
		compares++;
		if (got < lo || got > hi)
		begin
			numErrors++;
			$display("CHECK FAILED %s expected %0d..%0d seen %0d",
				what, lo, hi, got);
		end
	endtask : check_count

	task automatic bus_select(input logic [3:0] a);
		logic nk;
		host.start_cond();
		host.wr_byte({SLAVE_ADDR, 1'b0}, nk);
		check_byte("address ack", 8'h00, {7'h00, nk});
		host.wr_byte({4'h0, a}, nk);
		check_byte("pointer ack", 8'h00, {7'h00, nk});
	endtask : bus_select

	task automatic bus_write(input logic [3:0] a, input int n);
		logic nk;
		bus_select(a);
		for (int i = 0; i < n; i++)
		begin
			host.wr_byte(wd[i], nk);
			check_byte("data ack", 8'h00, {7'h00, nk});
		end
		host.stop_cond();
	endtask : bus_write

	task automatic bus_read(input logic [3:0] a, input int n);
		logic nk;
		bus_select(a);
		host.start_cond();
		host.wr_byte({SLAVE_ADDR, 1'b1}, nk);
		check_byte("read ack", 8'h00, {7'h00, nk});
		for (int i = 0; i < n; i++)
			host.rd_byte(i == n - 1, rd[i]);
		host.stop_cond();
	endtask : bus_read

	task automatic test_reset_values();
		logic [7:0] exp;
		bus_read(4'h8, 16);
		for (int k = 0; k < 16; k++)
		begin
			exp = k < 8 ? CTRL_RESET[8*k +: 8] : TIME_RESET[8*k-64 +: 8];
			if (k != 8)
				check_byte("reset value", exp, rd[k]);
		end
	endtask : test_reset_values

	task automatic test_square();
		sqEdges = 0;
		fixEdges = 0;
		#4800;
		check_count("square top rate", 98, 102, sqEdges);
		check_count("fixed top rate", 98, 102, fixEdges);
		wd[0] = 8'h00;
		bus_write(4'ha, 1);
		sqEdges = 0;
		fixEdges = 0;
		#4800;
		check_count("outputs off", 0, 0, sqEdges + fixEdges);
		wd[0] = 8'h40;
		bus_write(4'ha, 1);
		for (int n = 1; n < 8; n += 3)
		begin
			wd[0] = {n[3:0], 4'h1};
			bus_write(4'h4, 1);
			sqEdges = 0;
			#(4800 << (n - 1));
			check_count("square rate", 98, 102, sqEdges);
		end
		check_count("fixed stays off", 0, 0, fixEdges);
	endtask : test_square

	task automatic test_wrap();
		wd[0] = 8'ha5;
		wd[1] = 8'h00;
		wd[2] = 8'h99;
		wd[3] = 8'h80;
		bus_write(4'he, 4);
		bus_read(4'he, 4);
		check_byte("storage", 8'ha5, rd[0]);
		check_byte("flags cleared", 8'h00, rd[1]);
		check_byte("hundredths", 8'h00, rd[2]);
		check_byte("halted seconds", 8'h80, rd[3]);
	endtask : test_wrap

	task automatic test_bad_address();
		logic nk;
		host.start_cond();
		host.wr_byte({SLAVE_ADDR ^ 7'h01, 1'b0}, nk);
		check_byte("foreign ack", 8'h01, {7'h00, nk});
		host.stop_cond();
	endtask : test_bad_address

	task automatic test_calendar();
		wd[0] = 8'h00;
		wd[1] = 8'h59;
		wd[2] = 8'h59;
		wd[3] = 8'h23;
		wd[4] = 8'h11;
		for (int c = 0; c < 4; c++)
		begin
			wd[5] = CAL[c][23:16];
			wd[6] = CAL[c][31:24];
			wd[7] = CAL[c][39:32];
			bus_write(4'h0, 8);
			repeat (16000) @(negedge clock);
			bus_read(4'h3, 5);
			check_byte("hour", 8'h00, rd[0]);
			check_byte("weekday", 8'h12, rd[1]);
			check_byte("date", CAL[c][15:8], rd[2]);
			check_byte("month", CAL[c][7:0], rd[3]);
			check_byte("year", CAL[c][39:32], rd[4]);
		end
	endtask : test_calendar

	task automatic test_watchdog();
		wd[0] = 8'h08;
		bus_write(4'h9, 1);
		repeat (900) @(negedge clock);
		check_byte("wdog early", 8'h01, {7'h00, watchdogTimeoutDriveN});
		repeat (1200) @(negedge clock);
		check_byte("wdog fired", 8'h00, {7'h00, watchdogTimeoutDriveN});
		bus_read(4'hf, 1);
		check_byte("wdog flag", 8'h80, rd[0]);
		wd[0] = 8'h00;
		bus_write(4'h9, 1);
		check_byte("wdog off", 8'h01, {7'h00, watchdogTimeoutDriveN});
	endtask : test_watchdog

	task automatic test_osc_stop();
		wd[0] = 8'h00;
		bus_write(4'hf, 1);
		bus_read(4'hf, 1);
		check_byte("flags clear", 8'h00, rd[0]);
		xtalRun = 1'b0;
		repeat (3 * STOP_CYC) @(negedge clock);
		xtalRun = 1'b1;
		bus_read(4'hf, 1);
		check_byte("osc stop flag", 8'h04, rd[0]);
	endtask : test_osc_stop

	// Bound just above the roughly nine milliseconds the tests need,
	// so a hang stays within the cycle budget
	initial
	begin
		#10_000_000;
		numErrors++;
		summarize();
	end

	initial
	begin
		repeat (3) @(negedge clock);
		rst = 1'b0;
		repeat (4) @(negedge clock);
		test_reset_values();
		test_square();
		test_wrap();
		test_bad_address();
		test_calendar();
		test_watchdog();
		test_osc_stop();
		summarize();
	end
endmodule : srtc_core_tb_top
